// ==== hdl/cib_cfg.svh ====
// Purpose: constants of the CAN interrupt code, timestamp and buffer RAM block
// Assumes: one 16-bit register per AXI word, byte address = 4 * word index
// Notes: printed offsets are halfword addresses, so the word index is (offset - base) / 2
`ifndef CIB_CFG_SVH
`define CIB_CFG_SVH

// module base and printed register offsets
`define CIB_BASE 20'hef000
`define CIB_OFS_GCR 20'hef100
`define CIB_OFS_TIM 20'hef102
`define CIB_OFS_GMX 20'hef104
`define CIB_OFS_GMB 20'hef106
`define CIB_OFS_BMX 20'hef108
`define CIB_OFS_BMB 20'hef10a
`define CIB_OFS_IEN 20'hef10c
`define CIB_OFS_IPND 20'hef10e
`define CIB_OFS_ICLR 20'hef110
`define CIB_OFS_CODE_ENABLE_VALUE 20'hef112
`define CIB_OFS_STP 20'hef114
`define CIB_OFS_EC 20'hef116
`define CIB_OFS_ED 20'hef118
`define CIB_OFS_TMR 20'hef11a

// address space: 144 words, 15 banks of 8 words, reserved bank ends at 128
`define CIB_WORDS 8'd144
`define CIB_BUFS 4'd15
`define CIB_RAM_WORDS 8'd120
`define CIB_BANK_SHIFT 3

// printed byte offsets of the words inside one buffer bank
`define CIB_BOFS_STAT 4'h0
`define CIB_BOFS_BUFFER_CAPTURE_TIME 4'h2
`define CIB_BOFS_DATD 4'h4
`define CIB_BOFS_DATC 4'h6
`define CIB_BOFS_DATB 4'h8
`define CIB_BOFS_DATA 4'ha
`define CIB_BOFS_ID0 4'hc
`define CIB_BOFS_ID1 4'he

// field positions
`define CIB_ST_BUSY_BIT 0
`define CIB_GCR_TSYNC_BIT 0
`define CIB_IPND_ERR_BIT 15
`define CIB_STP_IST_LSB 8
`define CIB_STP_IRQ_BIT 12

// reset values and answers
`define CIB_REG_RST 16'h0000
`define CIB_RESP_OKAY 2'h0
`define CIB_RESP_DECERR 2'h3

`endif

// ==== hdl/cib_pkg.sv ====
// Purpose: types shared by the CAN interrupt code, timestamp and buffer RAM block
// Assumes: protocol engine runs on the same clock as the bus
// Notes: constants live in cib_cfg.svh
package cib_pkg;

   // one access of the protocol engine to the buffer RAM
   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] index;
      logic [15:0] wdata;
   } cib_eng_req_t;

   // frame events reported by the protocol engine, each a one-cycle pulse
   typedef struct packed {
      logic bit_tick;
      logic ack_slot;
      logic frame_ok;
      logic [3:0] frame_buf;
      logic bus_error;
   } cib_frame_evt_t;

   // configuration handed on to the protocol engine
   typedef struct packed {
      logic [15:0] global_configuration;
      logic [15:0] bit_timing_setup;
      logic [15:0] global_mask_extended;
      logic [15:0] global_mask_base;
      logic [15:0] basic_mask_extended;
      logic [15:0] basic_mask_base;
   } cib_ctl_t;

endpackage

// ==== hdl/cib_top.sv ====
// Purpose: interrupt code encoder, bit-time timestamp counter and shared buffer RAM of a CAN controller
// Assumes: engine events are synchronous to aclk; AXI4-Lite slave, 16-bit registers in the low lanes
// Notes: buffer RAM has no reset; capture, engine and CPU share one RAM port per cycle
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cib_cfg.svh"

module cib_top
   import cib_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cib_eng_req_t eng_req,
   output logic eng_ready,
   output logic [15:0] eng_rdata,
   input wire cib_frame_evt_t frame_evt,
   input wire logic [14:0] buf_event,
   input wire logic [15:0] error_counters,
   input wire logic [15:0] error_diagnostic,
   output cib_ctl_t ctl,
   output logic irq_req,
   output logic [3:0] interrupt_source_code
);

   // word indices of the control registers, derived from the printed offsets
   localparam logic [7:0] IX_GCR = 8'((`CIB_OFS_GCR - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_TIM = 8'((`CIB_OFS_TIM - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_GMX = 8'((`CIB_OFS_GMX - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_GMB = 8'((`CIB_OFS_GMB - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_BMX = 8'((`CIB_OFS_BMX - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_BMB = 8'((`CIB_OFS_BMB - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_IEN = 8'((`CIB_OFS_IEN - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_IPND = 8'((`CIB_OFS_IPND - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_ICLR = 8'((`CIB_OFS_ICLR - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_CODE_ENABLE_VALUE = 8'((`CIB_OFS_CODE_ENABLE_VALUE - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_STP = 8'((`CIB_OFS_STP - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_EC = 8'((`CIB_OFS_EC - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_ED = 8'((`CIB_OFS_ED - `CIB_BASE) >> 1);
   localparam logic [7:0] IX_TMR = 8'((`CIB_OFS_TMR - `CIB_BASE) >> 1);
   localparam logic [2:0] W_STAT = 3'(`CIB_BOFS_STAT >> 1);
   localparam logic [2:0] W_BUFFER_CAPTURE_TIME = 3'(`CIB_BOFS_BUFFER_CAPTURE_TIME >> 1);

   // byte-lane merge, shared by registers and RAM
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // priority code: error first, then lowest buffer, code n+1
   function automatic logic [4:0] encode(input logic [15:0] req);
      logic [4:0] r;
      r = 5'h00;
      if (req[`CIB_IPND_ERR_BIT])
         r = 5'h10;
      else
         for (int i = 14; i >= 0; i--)
            if (req[i])
               r = {1'b1, 4'(i + 1)};
      encode = r;
   endfunction

   logic [15:0] buf_ram [0:119];
   logic [15:0] gcr, tim, gmx, gmb, bmx, bmb, ien, code_enable_value, ipnd, timer, ack_sample, ts_val;
   logic [7:0] wix, rix;
   logic [15:0] wval;
   logic [1:0] wbe;
   logic aw_held, w_held, ar_held, ts_pend, busy, ram_we, sync_clr, reg_wr;
   logic [3:0] ts_buf;
   logic wr_ram, rd_ram, wr_want, rd_want, eng_go, cpu_w_go, cpu_r_go, wr_done, rd_done;
   logic [6:0] wram_ix, rram_ix;
   logic [1:0] eff_be;
   logic [15:0] set_mask, clr_mask, reg_rd;
   logic [4:0] next_code;

   assign ctl = '{gcr, tim, gmx, gmb, bmx, bmb};
   // words below 120 are buffer RAM
   assign wr_ram = wix < `CIB_RAM_WORDS;
   assign rd_ram = rix < `CIB_RAM_WORDS;
   assign wram_ix = wix[6:0];
   assign rram_ix = rix[6:0];
   assign wr_want = aw_held && w_held && !s_axi_bvalid && wr_ram;
   assign rd_want = ar_held && !s_axi_rvalid && rd_ram;
   // single RAM port, capture beats engine beats CPU
   assign eng_go = eng_req.valid && !ts_pend;
   assign eng_ready = eng_go;
   assign cpu_w_go = wr_want && !ts_pend && !eng_req.valid;
   assign cpu_r_go = rd_want && !ts_pend && !eng_req.valid && !wr_want;
   // state bit 0 marks busy bank
   assign busy = buf_ram[{wram_ix[6:3], 3'h0}][`CIB_ST_BUSY_BIT];
   assign eff_be = !busy ? wbe : (wram_ix[2:0] == W_STAT ? (wbe & 2'b01) : 2'b00);
   assign ram_we = cpu_w_go && (eff_be != 2'b00);
   // register accesses complete as soon as both halves are held
   assign wr_done = aw_held && w_held && !s_axi_bvalid && (!wr_ram || cpu_w_go);
   assign rd_done = ar_held && !s_axi_rvalid && (!rd_ram || cpu_r_go);
   assign reg_wr = wr_done && !wr_ram;
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !ar_held;

   // write address and data are taken independently, in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wix <= 8'h00;
         wval <= 16'h0000;
         wbe <= 2'b00;
      end
      else
      begin
         if (s_axi_awvalid && !aw_held)
         begin
            aw_held <= 1'b1;
            wix <= s_axi_awaddr[9:2];
         end
         else if (wr_done)
            aw_held <= 1'b0;
         if (s_axi_wvalid && !w_held)
         begin
            w_held <= 1'b1;
            wval <= s_axi_wdata[15:0];
            wbe <= s_axi_wstrb[1:0];
         end
         else if (wr_done)
            w_held <= 1'b0;
      end
   end
   // write response, DECERR above 144 words
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CIB_RESP_OKAY;
      end
      else if (wr_done)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wix >= `CIB_WORDS) ? `CIB_RESP_DECERR : `CIB_RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // register read mux; reserved words and the clear register read zero
   always_comb
   begin
      case (rix)
         IX_GCR: reg_rd = gcr;
         IX_TIM: reg_rd = tim;
         IX_GMX: reg_rd = gmx;
         IX_GMB: reg_rd = gmb;
         IX_BMX: reg_rd = bmx;
         IX_BMB: reg_rd = bmb;
         IX_IEN: reg_rd = ien;
         IX_IPND: reg_rd = ipnd;
         IX_CODE_ENABLE_VALUE: reg_rd = code_enable_value;
         // code and flag visible in the status word
         IX_STP: reg_rd = 16'({irq_req, interrupt_source_code}) << `CIB_STP_IST_LSB;
         IX_EC: reg_rd = error_counters;
         IX_ED: reg_rd = error_diagnostic;
         IX_TMR: reg_rd = timer;
         default: reg_rd = 16'h0000;
      endcase
   end

   // read channel; RAM reads wait for their slot on the shared port
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ar_held <= 1'b0;
         rix <= 8'h00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CIB_RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && !ar_held)
         begin
            ar_held <= 1'b1;
            rix <= s_axi_araddr[9:2];
         end
         else if (rd_done)
            ar_held <= 1'b0;
         if (rd_done)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_ram ? buf_ram[rram_ix] : reg_rd};
            s_axi_rresp <= (rix >= `CIB_WORDS) ? `CIB_RESP_DECERR : `CIB_RESP_OKAY;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   // bank n word w at 8n+w; timestamp word 1
   always_ff @(posedge aclk)
   begin
      if (ts_pend)
         buf_ram[{ts_buf, W_BUFFER_CAPTURE_TIME}] <= ts_val;
      else if (eng_go && eng_req.write)
         buf_ram[eng_req.index] <= eng_req.wdata;
      else if (ram_we)
         buf_ram[wram_ix] <= merge16(buf_ram[wram_ix], wval, eff_be);
   end

   // engine read data, one cycle after the grant
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         eng_rdata <= 16'h0000;
      else if (eng_go && !eng_req.write)
         eng_rdata <= buf_ram[eng_req.index];
   end

   // control registers, byte-lane writes; read-only words ignore writes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gcr <= `CIB_REG_RST;
         tim <= `CIB_REG_RST;
         gmx <= `CIB_REG_RST;
         gmb <= `CIB_REG_RST;
         bmx <= `CIB_REG_RST;
         bmb <= `CIB_REG_RST;
         ien <= `CIB_REG_RST;
         code_enable_value <= `CIB_REG_RST;
      end
      else if (reg_wr)
      begin
         case (wix)
            IX_GCR: gcr <= merge16(gcr, wval, wbe);
            IX_TIM: tim <= merge16(tim, wval, wbe);
            IX_GMX: gmx <= merge16(gmx, wval, wbe);
            IX_GMB: gmb <= merge16(gmb, wval, wbe);
            IX_BMX: bmx <= merge16(bmx, wval, wbe);
            IX_BMB: bmb <= merge16(bmb, wval, wbe);
            // enable bits per buffer and for errors
            IX_IEN: ien <= merge16(ien, wval, wbe);
            IX_CODE_ENABLE_VALUE: code_enable_value <= merge16(code_enable_value, wval, wbe);
            default: ;
         endcase
      end
   end

   // engine buffer events and bus errors, gated by the enables
   assign set_mask = {frame_evt.bus_error, buf_event} & ien;
   // ones written to the clear word, respecting byte lanes
   assign clr_mask = (reg_wr && wix == IX_ICLR) ? merge16(16'h0000, wval, wbe) : 16'h0000;
   // a set in the same cycle as a clear wins
   // no other write path reaches the pending flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ipnd <= `CIB_REG_RST;
      else
         ipnd <= (ipnd & ~clr_mask) | set_mask;
   end
   assign next_code = encode(ipnd & code_enable_value);
   // flag and code from flip-flops, one cycle behind the flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_req <= 1'b0;
         interrupt_source_code <= 4'h0;
      end
      else
      begin
         irq_req <= next_code[4];
         interrupt_source_code <= next_code[3:0];
      end
   end

   // buffer 0 frame with sync on zeroes the counter
   // sync only when the configuration bit is set
   assign sync_clr = frame_evt.frame_ok && frame_evt.frame_buf == 4'h0 && gcr[`CIB_GCR_TSYNC_BIT];

   // free-running count of bit times, wraps at 16 bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         timer <= `CIB_REG_RST;
      else if (sync_clr)
         timer <= 16'h0000;
      else if (frame_evt.bit_tick)
         timer <= timer + 16'h0001;
   end

   // sample at the ack slot, write the bank once the frame succeeds
   // the capture takes the RAM port next cycle, so engine and CPU stall one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ack_sample <= 16'h0000;
         ts_pend <= 1'b0;
         ts_buf <= 4'h0;
         ts_val <= 16'h0000;
      end
      else
      begin
         if (frame_evt.ack_slot)
            ack_sample <= timer;
         ts_pend <= frame_evt.frame_ok && frame_evt.frame_buf < `CIB_BUFS;
         if (frame_evt.frame_ok)
         begin
            ts_buf <= frame_evt.frame_buf;
            ts_val <= ack_sample;
         end
      end
   end

   // checks
   code_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ipnd[`CIB_IPND_ERR_BIT] && code_enable_value[`CIB_IPND_ERR_BIT] |=> irq_req && interrupt_source_code == 4'h0)
      else $error("error request not coded first");
   code_none_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ipnd & code_enable_value) == 16'h0000 |=> !irq_req && interrupt_source_code == 4'h0)
      else $error("code present without request");
   code_buf_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ipnd & code_enable_value) == 16'h0001 |=> irq_req && interrupt_source_code == 4'h1)
      else $error("buffer 0 not coded as one");
   flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      set_mask != 16'h0000 |=> (ipnd & $past(set_mask)) == $past(set_mask))
      else $error("pending flag not set");
   flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (clr_mask & ~set_mask) != 16'h0000 |=> (ipnd & $past(clr_mask & ~set_mask)) == 16'h0000)
      else $error("pending flag not cleared");
   tick_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      frame_evt.bit_tick && !sync_clr |=> timer == $past(timer) + 16'h0001)
      else $error("counter missed a bit time");
   sync_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sync_clr |=> timer == 16'h0000 && ts_pend && ts_buf == 4'h0)
      else $error("sync did not zero counter");
   ram_stall_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ts_pend |-> !eng_ready && !cpu_w_go && !cpu_r_go)
      else $error("RAM port granted twice");
   busy_guard_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu_w_go && busy && wram_ix[2:0] != W_STAT |=> buf_ram[$past(wram_ix)] == $past(buf_ram[wram_ix]))
      else $error("write reached busy buffer");
   reg_nowait_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_held && w_held && !s_axi_bvalid && !wr_ram |=> s_axi_bvalid)
      else $error("register write stalled");

endmodule // cib_top
`default_nettype wire

// ==== verification/cib_eng_model.sv ====
// Purpose: behavioural protocol engine on the far side of the buffer RAM and event pins
// Assumes: same clock as the bus side; every change lands right after a rising edge
// Notes: a released request shows inverted fields so stale values are never trusted
`timescale 1ns/100ps
`default_nettype none
module cib_eng_model
   import cib_pkg::*;
(
   input wire logic aclk,
   input wire logic eng_ready,
   input wire logic [15:0] eng_rdata,
   output var cib_eng_req_t eng_req,
   output var cib_frame_evt_t frame_evt,
   output var logic [14:0] buf_event
);
   // quiet outputs at time zero
   initial
   begin
      eng_req = '0;
      frame_evt = '0;
      buf_event = '0;
   end

   task automatic pulse(input logic [14:0] m, input logic e);
      @(posedge aclk);
      buf_event <= m;
      frame_evt.bus_error <= e;
      @(posedge aclk);
      buf_event <= '0;
      frame_evt.bus_error <= 1'b0;
   endtask

   // one bit time every two cycles
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         frame_evt.bit_tick <= 1'b1;
         @(posedge aclk);
         frame_evt.bit_tick <= 1'b0;
      end
   endtask

   // ack slot always before frame end
   task automatic frame(input logic [3:0] b);
      @(posedge aclk);
      frame_evt.ack_slot <= 1'b1;
      @(posedge aclk);
      frame_evt.ack_slot <= 1'b0;
      frame_evt.frame_ok <= 1'b1;
      frame_evt.frame_buf <= b;
      @(posedge aclk);
      frame_evt.frame_ok <= 1'b0;
      frame_evt.frame_buf <= ~b;
   endtask

   // request held until granted, data the cycle after
   task automatic access(input logic w, input logic [6:0] i, input logic [15:0] d, output logic [15:0] q);
      @(posedge aclk);
      eng_req <= '{1'b1, w, i, d};
      do @(negedge aclk); while (!eng_ready);
      @(posedge aclk);
      eng_req <= '{1'b0, 1'b0, ~i, ~d};
      @(negedge aclk);
      q = eng_rdata;
   endtask
endmodule // cib_eng_model
`default_nettype wire

// ==== verification/cib_top_tb_top.sv ====
// Purpose: self-checking bench for the interrupt code, timestamp and buffer RAM block
// Assumes: handshakes decided at the falling edge, driven after the rising edge
// Notes: buffer RAM is not reset, so every status word is cleared before use
`timescale 1ns/100ps
`default_nettype none
`include "cib_cfg.svh"
module cib_top_tb_top
   import cib_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [9:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, eng_ready, irq_req;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] eng_rdata, ec, ed, pnd, ien, code_enable_value, q, v;
   logic [3:0] interrupt_source_code;
   cib_eng_req_t eng_req;
   cib_frame_evt_t frame_evt;
   logic [14:0] buf_event;
   cib_ctl_t ctl;
   int n_mismatch = 0, checks_done = 0, b, n, cnt;
   int rst_ix[11] = '{128, 129, 130, 131, 132, 133, 134, 135, 137, 138, 141};

   cib_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eng_req(eng_req),
      .eng_ready(eng_ready), .eng_rdata(eng_rdata), .frame_evt(frame_evt), .buf_event(buf_event),
      .error_counters(ec), .error_diagnostic(ed), .ctl(ctl), .irq_req(irq_req),
      .interrupt_source_code(interrupt_source_code));

   cib_eng_model i_eng (.aclk(aclk), .eng_ready(eng_ready), .eng_rdata(eng_rdata), .eng_req(eng_req),
      .frame_evt(frame_evt), .buf_event(buf_event));

   // 50 MHz clock
   always #10 aclk = ~aclk;

   // compares for data words and for bus answers
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
      chk({14'h0, g}, {14'h0, e}, "resp");
   endtask

   // axi write; address and data released each when taken
   task automatic wr(input int i, input logic [15:0] d, input logic [1:0] s, input logic [1:0] er);
      logic a, w;
      a = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      awaddr <= 10'(i * 4);
      wdata <= {16'h0000, d};
      wstrb <= {2'b00, s};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (a || w)
      begin
         @(negedge aclk);
         a = a && !awready;
         w = w && !wready;
         @(posedge aclk);
         awvalid <= a;
         wvalid <= w;
      end
      do @(negedge aclk); while (!bvalid);
      chk_r(bresp, er);
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   // axi read; waits on the answer, no fixed latency assumed
   task automatic rd(input int i, output logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      araddr <= 10'(i * 4);
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      chk_r(rresp, er);
      d = rdata[15:0];
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   task automatic rc(input int i, input logic [15:0] e);
      logic [15:0] g;
      rd(i, g, `CIB_RESP_OKAY);
      chk(g, e, "read");
   endtask

   // expected {flag, code}: error first, then lowest buffer
   function automatic logic [4:0] enc(input logic [15:0] p);
      if (p[15])
         return 5'h10;
      for (int i = 0; i < 15; i++)
         if (p[i])
            return {1'b1, 4'(i + 1)};
      return 5'h00;
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog, far beyond the expected run length
   initial
   begin
      repeat (40000) @(posedge aclk);
      n_mismatch++;
      $display("BAD %0t watchdog expired", $time);
      results();
   end

   // main sequence
   initial
   begin
      void'($urandom(32'he6d1b6dc));
      ec = 16'($urandom);
      ed = 16'($urandom);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rst_ix[k])
         rc(rst_ix[k], 16'h0000);
      rc(139, ec);
      rc(140, ed);
      // control words read back and reach the engine
      for (int k = 0; k < 6; k++)
      begin
         v = 16'($urandom);
         wr(128 + k, v, 2'b11, `CIB_RESP_OKAY);
         rc(128 + k, v);
         chk(ctl[95 - 16 * k -: 16], v, "ctl");
         if (k == 1)
            q = v;
      end
      wr(129, 16'h5aa5, 2'b01, `CIB_RESP_OKAY);
      rc(129, {q[15:8], 8'ha5});
      wr(135, 16'hffff, 2'b11, `CIB_RESP_OKAY);
      rc(135, 16'h0000);
      wr(143, 16'hffff, 2'b11, `CIB_RESP_OKAY);
      wr(144, 16'hffff, 2'b11, `CIB_RESP_DECERR);
      rd(255, q, `CIB_RESP_DECERR);
      chk(q, 16'h0000, "decerr");
      // every code alone, then random mixes with partial clears
      pnd = '0;
      for (int k = 0; k < 40; k++)
      begin
         ien = (k < 16) ? 16'hffff : 16'($urandom);
         code_enable_value = (k < 16) ? 16'hffff : (k == 16) ? 16'h00ff : 16'($urandom);
         wr(134, ien, 2'b11, `CIB_RESP_OKAY);
         wr(137, code_enable_value, 2'b11, `CIB_RESP_OKAY);
         v = (k < 16) ? 16'h0001 << k : 16'($urandom & $urandom);
         i_eng.pulse(v[14:0], v[15]);
         pnd = pnd | (v & ien);
         repeat (3) @(posedge aclk);
         @(negedge aclk);
         chk({11'h0, irq_req, interrupt_source_code}, {11'h0, enc(pnd & code_enable_value)}, "code");
         rc(138, {3'b000, enc(pnd & code_enable_value), 8'h00});
         rc(135, pnd);
         v = (k < 16) ? 16'hffff : 16'($urandom);
         wr(136, v, 2'b11, `CIB_RESP_OKAY);
         pnd = pnd & ~v;
      end
      rc(135, pnd);
      // buffers idle before timestamps and RAM traffic
      for (int k = 0; k < 15; k++)
         wr(8 * k, 16'h0000, 2'b11, `CIB_RESP_OKAY);
      cnt = 0;
      for (int k = 0; k < 4; k++)
      begin
         b = (k == 1 || k == 2) ? 0 : 1 + $urandom_range(13);
         wr(128, {15'h0000, k[1]}, 2'b11, `CIB_RESP_OKAY);
         n = 3 + $urandom_range(30);
         i_eng.ticks(n);
         cnt = cnt + n;
         rc(141, 16'(cnt));
         i_eng.frame(4'(b));
         rc(8 * b + 1, 16'(cnt));
         if (k == 2)
            cnt = 0;
         rc(141, 16'(cnt));
      end
      // both ports on the same words, then at the same time on neighbouring words
      for (int k = 0; k < 12; k++)
      begin
         b = 8 * $urandom_range(14) + 2 + $urandom_range(5);
         v = 16'($urandom);
         wr(b, v, 2'b11, `CIB_RESP_OKAY);
         i_eng.access(1'b0, 7'(b), 16'h0000, q);
         chk(q, v, "eng read");
         // engine asks one cycle late, so the held CPU write has to wait
         fork
            begin
               @(posedge aclk);
               i_eng.access(1'b1, 7'(b), ~v, q);
            end
            wr(b ^ 1, v, 2'b11, `CIB_RESP_OKAY);
         join
         rc(b, ~v);
         rc(b ^ 1, v);
      end
      // byte lanes, then the busy lock on buffer 4
      wr(34, 16'h1234, 2'b11, `CIB_RESP_OKAY);
      wr(34, 16'habcd, 2'b10, `CIB_RESP_OKAY);
      rc(34, 16'hab34);
      i_eng.access(1'b1, 7'd32, 16'h30c1, q);
      wr(34, 16'h5555, 2'b11, `CIB_RESP_OKAY);
      rc(34, 16'hab34);
      wr(32, 16'hffd1, 2'b11, `CIB_RESP_OKAY);
      rc(32, 16'h30d1);
      // clear and a new event in one cycle: the event wins
      wr(134, 16'hffff, 2'b11, `CIB_RESP_OKAY);
      fork
         wr(136, 16'hffff, 2'b11, `CIB_RESP_OKAY);
         begin
            @(posedge aclk);
            i_eng.pulse(15'h0004, 1'b0);
         end
      join
      rc(135, 16'h0004);
      // mid-run reset drops flags, enables and the code
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(135, 16'h0000);
      rc(134, 16'h0000);
      chk({11'h0, irq_req, interrupt_source_code}, 16'h0000, "reset code");
      results();
   end
endmodule // cib_top_tb_top
`default_nettype wire
